// ### pps_pulse_gen.sv
// Timing pulse generator with APB register access.
`timescale 1ns/1ns
module pps_pulse_gen
#(
    parameter int TICK_CYCLES = pps_pkg::TICK_CYC,
    parameter logic [31:0] WIDTH_RST = 32'(pps_pkg::WIDTH_CYC)
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Navigation engine: 10 ms ticks per time scale and fix strobe.
    input wire logic [3:0] ref_tick,
    input wire logic fix_strobe,
    // Pulse and time message request.
    output logic timing_pulse_output,
    output logic zda_req,
    output logic [31:0] zda_stamp
);
    import pps_pkg::*;

    // ****************************************************************
    // Register decode
    // ****************************************************************

    // Returns one when the address names a mapped register.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_CTRL) || (a == OFS_INTERVAL) ||
            (a == OFS_DELAY) || (a == OFS_WIDTH) || (a == OFS_STALE) ||
            (a == OFS_STATUS) || (a == OFS_COUNT);
    endfunction

    pps_apb_req_s req;
    pps_cfg_s cfg_ff;
    pps_cfg_s nxt_cfg;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic wr_take;
    logic [31:0] status_word;

    logic stale_ff;
    logic nxt_stale;
    logic supp_ff;
    logic nxt_supp;
    logic [15:0] age_ff;
    logic [15:0] nxt_age;
    logic [6:0] sub_ff;
    logic [6:0] nxt_sub;
    logic [15:0] ic_ff;
    logic [15:0] nxt_ic;
    logic [31:0] wcnt_ff;
    logic [31:0] nxt_wcnt;
    logic [31:0] pcount_ff;
    logic [31:0] nxt_pcount;
    pps_state_e state_ff;
    pps_state_e nxt_state;
    logic out_ff;
    logic nxt_out;
    logic zda_ff;
    logic nxt_zda;
    logic [31:0] stamp_ff;
    logic [31:0] nxt_stamp;
    logic tick;
    logic realign;
    logic [31:0] lead;
    logic start;
    logic [15:0] ivl;

    assign req = '{psel, penable, pwrite, paddr, pwdata};
    // The write lands on the edge where the master sees pready high.
    assign wr_take = req.psel && req.penable && req.pwrite && pready_ff;
    assign status_word = {age_ff, 13'h0000, (state_ff == PS_ACTIVE),
        supp_ff, stale_ff};

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Answer on the second access cycle; unmapped addresses raise pslverr.
    always_comb
    begin
        nxt_pready = req.psel && req.penable && !pready_ff;
        nxt_pslverr = nxt_pready && !is_mapped(req.paddr);
        nxt_prdata = 32'h0000_0000;
        if (nxt_pready && !req.pwrite)
        begin
            unique case (req.paddr)
                OFS_CTRL: nxt_prdata = {28'h0000000, cfg_ff.zda_en,
                    cfg_ff.tscale, cfg_ff.falling};
                OFS_INTERVAL: nxt_prdata = {16'h0000, cfg_ff.interval};
                OFS_DELAY: nxt_prdata = cfg_ff.delay;
                OFS_WIDTH: nxt_prdata = cfg_ff.width;
                OFS_STALE: nxt_prdata = {16'h0000, cfg_ff.stale_limit};
                OFS_STATUS: nxt_prdata = status_word;
                OFS_COUNT: nxt_prdata = pcount_ff;
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
        nxt_cfg = cfg_ff;
        if (wr_take)
        begin
            unique case (req.paddr)
                OFS_CTRL:
                begin
                    nxt_cfg.falling = req.pwdata[CTRL_POL_BIT]; // R02
                    nxt_cfg.tscale =
                        pps_ts_e'(req.pwdata[CTRL_TS_LSB +: 2]); // R04
                    nxt_cfg.zda_en = req.pwdata[CTRL_ZDA_BIT];
                end
                OFS_INTERVAL:
                begin
                    // Out-of-range intervals are clamped to the limits.
                    if (req.pwdata > {16'h0000, INTERVAL_MAX}) // R01
                        nxt_cfg.interval = INTERVAL_MAX;
                    else if (req.pwdata[15:0] < INTERVAL_MIN)
                        nxt_cfg.interval = INTERVAL_MIN;
                    else
                        nxt_cfg.interval = req.pwdata[15:0];
                end
                OFS_DELAY: nxt_cfg.delay = req.pwdata;
                OFS_WIDTH: nxt_cfg.width = req.pwdata;
                OFS_STALE: nxt_cfg.stale_limit = req.pwdata[15:0];
                default: nxt_cfg = cfg_ff;
            endcase
        end
    end

    // Register the bus answer and the configuration.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            cfg_ff.falling <= 1'b0; // R02
            cfg_ff.tscale <= TS_SAT; // R04
            cfg_ff.zda_en <= 1'b0;
            cfg_ff.interval <= INTERVAL_RST;
            cfg_ff.delay <= DELAY_RST; // R03
            cfg_ff.width <= WIDTH_RST; // R10
            cfg_ff.stale_limit <= STALE_RST; // R06
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            cfg_ff <= nxt_cfg;
        end
    end

    // ****************************************************************
    // Reference phase
    // ****************************************************************

    // The local clock never realigns, so it runs on the pclk divider only.
    assign realign = (cfg_ff.tscale != TS_LOCAL) &&
        ref_tick[cfg_ff.tscale]; // R08
    // The lead is kept inside one tick period.
    assign lead = (cfg_ff.delay < 32'(TICK_CYCLES)) ? cfg_ff.delay :
        32'(TICK_CYCLES - 1); // R03

    pps_phase_ctr #(
        .PERIOD(TICK_CYCLES)
    ) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .realign(realign),
        .lead(lead),
        .tick(tick)
    );

    // ****************************************************************
    // Fix age and interval
    // ****************************************************************

    assign ivl = cfg_ff.interval;
    assign start = tick && (ic_ff == ivl - 16'h0001); // R01

    // Age in seconds since the last fix, saturating; intervals in ticks.
    always_comb
    begin
        nxt_sub = sub_ff;
        nxt_age = age_ff;
        if (fix_strobe)
        begin
            nxt_sub = 7'h00;
            nxt_age = 16'h0000;
        end
        else if (tick)
        begin
            if (sub_ff == 7'(TICKS_PER_SEC - 1))
            begin
                nxt_sub = 7'h00;
                if (age_ff != 16'hffff)
                    nxt_age = age_ff + 16'h0001;
            end
            else
                nxt_sub = sub_ff + 7'h01;
        end
        nxt_stale = (age_ff > cfg_ff.stale_limit); // R06
        nxt_supp = nxt_stale && (cfg_ff.tscale != TS_LOCAL); // R07
        nxt_ic = ic_ff;
        if (tick)
            nxt_ic = (ic_ff >= ivl - 16'h0001) ? 16'h0000 : ic_ff + 16'h0001;
    end

    // Register the age and interval state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_ff <= 7'h00;
            age_ff <= 16'h0000;
            stale_ff <= 1'b0;
            supp_ff <= 1'b0;
            ic_ff <= 16'h0000;
        end
        else
        begin
            sub_ff <= nxt_sub;
            age_ff <= nxt_age;
            stale_ff <= nxt_stale;
            supp_ff <= nxt_supp;
            ic_ff <= nxt_ic;
        end
    end

    // ****************************************************************
    // Pulse shaping and time message
    // ****************************************************************

    // Start a pulse on the interval tick unless suppressed; hold for width.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_wcnt = wcnt_ff;
        nxt_pcount = pcount_ff;
        nxt_zda = 1'b0;
        nxt_stamp = stamp_ff;
        if (start && !supp_ff) // R06 R07
        begin
            nxt_state = PS_ACTIVE;
            nxt_wcnt = (cfg_ff.width == 32'h0000_0000) ? 32'h0000_0000 :
                cfg_ff.width - 32'h0000_0001; // R10
            nxt_pcount = pcount_ff + 32'h0000_0001;
            nxt_zda = cfg_ff.zda_en; // R09
            nxt_stamp = pcount_ff + 32'h0000_0001; // R09
        end
        else
        begin
            unique case (state_ff)
                PS_IDLE: nxt_state = PS_IDLE;
                PS_ACTIVE:
                begin
                    if (wcnt_ff == 32'h0000_0000)
                        nxt_state = PS_IDLE; // R10
                    else
                        nxt_wcnt = wcnt_ff - 32'h0000_0001;
                end
            endcase
        end
        nxt_out = (nxt_state == PS_ACTIVE) ^ cfg_ff.falling; // R02
    end

    // Register the pulse state and outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= PS_IDLE;
            wcnt_ff <= 32'h0000_0000;
            pcount_ff <= 32'h0000_0000;
            out_ff <= 1'b0;
            zda_ff <= 1'b0;
            stamp_ff <= 32'h0000_0000;
        end
        else
        begin
            state_ff <= nxt_state;
            wcnt_ff <= nxt_wcnt;
            pcount_ff <= nxt_pcount;
            out_ff <= nxt_out;
            zda_ff <= nxt_zda;
            stamp_ff <= nxt_stamp;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign timing_pulse_output = out_ff;
    assign zda_req = zda_ff;
    assign zda_stamp = stamp_ff;
endmodule

// ### pps_pkg.sv
// Package of constants, types and register map for the timing pulse block.
// How it works
// R01: Pulses are spaced by a set interval in 10 ms steps, 10 ms to 60 s.
// R02: The active edge rises after reset; a polarity bit makes it fall.
// R03: The pulse moves earlier by a delay in cycles, zero after reset.
// R04: The reference is satellite time, UTC, the local clock or GLONASS time.
// R05: The phase free-runs between fixes, extrapolating from the last one; here it realigns on each tick of a selected non-local reference scale instead.
// R06: Pulses stop while the fix is older than the limit, 60 s by default.
// R07: With the local receiver clock selected the staleness limit is ignored.
// R08: Each active edge lands on a tick of the reference and holds no time.
// R09: With messages on, a request stamped with each leading edge follows it.
// R10: The pulse stays active for a set width, 5 ms by default, then idles.
package pps_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WIDTH_MS = 5;
    localparam int WIDTH_CYC = WIDTH_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_SEC = 1000 / TICK_MS;
    localparam int INTERVAL_MAX_S = 60;
    localparam logic [15:0] INTERVAL_MIN = 16'h0001;
    localparam logic [15:0] INTERVAL_MAX = 16'(INTERVAL_MAX_S * TICKS_PER_SEC);

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INTERVAL = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h08;
    localparam logic [7:0] OFS_WIDTH = 8'h0c;
    localparam logic [7:0] OFS_STALE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;

    // Control field positions.
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_TS_LSB = 1;
    localparam int CTRL_ZDA_BIT = 3;
    // Status field positions.
    localparam int ST_STALE_BIT = 0;
    localparam int ST_SUPP_BIT = 1;
    localparam int ST_ACT_BIT = 2;
    localparam int ST_AGE_LSB = 16;

    // Reset values.
    localparam logic [15:0] INTERVAL_RST = 16'(TICKS_PER_SEC);
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;
    localparam logic [15:0] STALE_RST = 16'h003c;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        TS_SAT,
        TS_UTC,
        TS_LOCAL,
        TS_GLO
    } pps_ts_e;

    typedef enum logic {
        PS_IDLE,
        PS_ACTIVE
    } pps_state_e;

    typedef struct packed {
        logic falling;
        pps_ts_e tscale;
        logic zda_en;
        logic [15:0] interval;
        logic [31:0] delay;
        logic [31:0] width;
        logic [15:0] stale_limit;
    } pps_cfg_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pps_apb_req_s;

endpackage

// ### pps_phase_ctr.sv
// Extrapolating 10 ms phase counter with an advanced tick output.
`timescale 1ns/1ns
module pps_phase_ctr
#(
    parameter int PERIOD = 500000
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Reference tick that realigns the phase.
    input wire logic realign,
    // Lead in cycles, already clamped below the period.
    input wire logic [31:0] lead,
    // Tick that fires lead cycles before each boundary.
    output logic tick
);
    import pps_pkg::*;

    localparam logic [31:0] LAST = 32'(PERIOD - 1);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // Free-run between reference ticks and restart on each one.
    always_comb
    begin
        if (realign) // R05
            nxt_cnt = 32'h0000_0000;
        else if (cnt_ff == LAST)
            nxt_cnt = 32'h0000_0000;
        else
            nxt_cnt = cnt_ff + 32'h0000_0001;
        nxt_tick = (nxt_cnt == LAST - lead); // R03
    end

    // Register the phase and the tick.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// ### pps_pulse_gen_asserts.sv
// Checker of port timing for the timing pulse generator.
`timescale 1ns/1ns
module pps_pulse_gen_chk
#(
    parameter int TICK_CYCLES = 50,
    parameter logic [31:0] WIDTH_RST = 32'h0000_000a
)
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pulse and time message request.
    input wire logic timing_pulse_output,
    input wire logic zda_req
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready held longer than one cycle");
    property p_rdy_cause;
        pready |-> psel && penable && $past(psel && penable);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("ready without two access cycles");
    property p_rdy_due;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_due: assert property (p_rdy_due)
        else $error("ready missing in second access cycle");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data)
        else $error("error response without ready or with data");
    property p_rd_idle;
        !pready |-> prdata == 32'h0000_0000 && !pslverr;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data or error outside a response");
    property p_zda_single;
        zda_req |=> !zda_req;
    endproperty
    a_zda_single: assert property (p_zda_single)
        else $error("message request longer than one cycle");
    property p_zda_edge;
        zda_req |-> timing_pulse_output != $past(timing_pulse_output);
    endproperty
    a_zda_edge: assert property (p_zda_edge)
        else $error("message request without a leading edge");
    property p_rst_quiet;
        $rose(presetn) |-> !pready && !zda_req && !timing_pulse_output;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not idle after reset");
endmodule

bind pps_pulse_gen pps_pulse_gen_chk
#(
    .TICK_CYCLES(TICK_CYCLES),
    .WIDTH_RST(WIDTH_RST)
)
chk_u
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timing_pulse_output(timing_pulse_output),
    .zda_req(zda_req)
);

// ### pps_sync_peer.sv
// Model of the device that synchronises its clock to the pulses.
`timescale 1ns/1ns
module pps_sync_peer
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pulse line, its idle level and the local time base.
    input wire logic pulse,
    input wire logic falling,
    input wire logic [31:0] now,
    // Edge count, edge spacing, active width and last edge time.
    output logic [31:0] n_edges,
    output logic [31:0] gap,
    output logic [31:0] width,
    output logic [31:0] lead_at
);
    logic prev;
    logic [31:0] run;

    // Leading edges are timed; active samples are counted per pulse.
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            {prev, n_edges, gap, width, lead_at, run} <= '0;
        end
        else
        begin
            prev <= pulse;
            if (pulse == !falling)
                run <= (prev == pulse) ? run + 1 : 32'h1;
            else if (prev == !falling)
                width <= run;
            if (pulse == !falling && prev != pulse)
            begin
                n_edges <= n_edges + 1;
                gap <= now - lead_at;
                lead_at <= now;
            end
        end
endmodule

// ### pps_pulse_generator_tb.sv
// Self-checking testbench of the timing pulse generator.
`timescale 1ns/1ns
module pps_pulse_generator_tb;
    import pps_pkg::*;
    localparam int TC = 50;
    localparam logic [31:0] WR = 32'h0000_000a;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic fix_strobe, timing_pulse_output, zda_req, fix_on, falling;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, zda_stamp, n_edges, gap, width, lead_at;
    logic [31:0] r, e0, last_stamp;
    logic [3:0] ref_tick;
    logic have_stamp;
    int n_fail, tests_run, cyc;

    pps_pulse_gen #(.TICK_CYCLES(TC), .WIDTH_RST(WR)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_tick(ref_tick), .fix_strobe(fix_strobe),
        .timing_pulse_output(timing_pulse_output), .zda_req(zda_req),
        .zda_stamp(zda_stamp));
    pps_sync_peer peer_u (.pclk(pclk), .presetn(presetn),
        .pulse(timing_pulse_output), .falling(falling), .now(cyc),
        .n_edges(n_edges), .gap(gap), .width(width), .lead_at(lead_at));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task results;
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until ready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k == 50)
            chk(32'h0, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // Waits for n more leading edges, bounded.
    task pulses(input int n);
        logic [31:0] s;
        int t;
        s = n_edges;
        t = 0;
        while (n_edges != s + n && t < 2000)
        begin
            @(posedge pclk);
            t++;
        end
        chk(n_edges, s + n);
    endtask

    // Clock of 20 ns.
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Navigation references: scale k ticks at phase 10*k, fixes at 25.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++)
            ref_tick[i] <= (cyc % TC == 10 * i);
        fix_strobe <= fix_on && (cyc % TC == 25);
        if (cyc == 60000)
        begin
            n_fail++;
            results;
        end
    end

    // Each message stamp follows the previous one by exactly one pulse.
    always @(posedge pclk)
        if (presetn && zda_req === 1'b1)
        begin
            if (have_stamp)
                chk(zda_stamp, last_stamp + 1);
            last_stamp = zda_stamp;
            have_stamp = 1'b1;
        end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ref_tick, fix_strobe, falling, have_stamp} = '0;
        fix_on = 1'b1;
        cyc = 0;
        n_fail = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_INTERVAL, 32'(INTERVAL_RST));
        rd(OFS_DELAY, DELAY_RST);
        rd(OFS_WIDTH, WR);
        rd(OFS_STALE, 32'(STALE_RST));
        rd(OFS_STATUS, 32'h0);
        rd(OFS_COUNT, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, OFS_INTERVAL, 32'h0);
        rd(OFS_INTERVAL, 32'(INTERVAL_MIN));
        apb(1'b1, OFS_INTERVAL, 32'hffff);
        rd(OFS_INTERVAL, 32'(INTERVAL_MAX));
        apb(1'b1, OFS_INTERVAL, 32'h0001_0000);
        rd(OFS_INTERVAL, 32'(INTERVAL_MAX));
        apb(1'b1, OFS_INTERVAL, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h8);
        pulses(3);
        chk(gap, TC);
        chk(width, WR);
        e0 = lead_at % TC;
        apb(1'b1, OFS_INTERVAL, 32'h2);
        pulses(3);
        chk(gap, 2 * TC);
        apb(1'b1, OFS_INTERVAL, 32'h1);
        apb(1'b1, OFS_WIDTH, 32'h3);
        pulses(3);
        chk(width, 32'h3);
        // Edges follow the ticks of the UTC and GLONASS reference scales.
        for (int k = 1; k < 4; k += 2)
        begin
            apb(1'b1, OFS_CTRL, 32'h8 | (k << 1));
            pulses(3);
            chk((lead_at - 10 * k) % TC, e0);
        end
        apb(1'b1, OFS_CTRL, 32'h8);
        apb(1'b1, OFS_DELAY, 32'h5);
        pulses(3);
        chk((lead_at + 5) % TC, e0);
        apb(1'b1, OFS_DELAY, 32'h0);
        falling <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h9);
        // A pulse ending during the switch can look like an edge to the peer.
        pulses(3);
        chk(width, 32'h3);
        repeat (10) @(posedge pclk);
        chk(32'(timing_pulse_output), 32'h1);
        falling <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h8);
        // A lost fix ages past a zero limit and stops the pulses.
        apb(1'b1, OFS_STALE, 32'h0);
        fix_on <= 1'b0;
        repeat (6000) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r & 32'h3, 32'h3);
        chk(r >> ST_AGE_LSB, 32'h1);
        e0 = n_edges;
        repeat (200) @(posedge pclk);
        chk(n_edges, e0);
        apb(1'b1, OFS_CTRL, 32'hc);
        pulses(2);
        chk(gap, TC);
        apb(1'b1, OFS_CTRL, 32'h8);
        fix_on <= 1'b1;
        repeat (60) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r & 32'h3, 32'h0);
        pulses(2);
        chk(32'(have_stamp), 32'h1);
        results;
    end
endmodule
